/* File: common/dbat_pkg.sv */
// Types shared by the DRAM bank address translator files.
// Assumes nothing beyond a SystemVerilog compiler.
package dbat_pkg;

   // ---------------------------------------------------------------
   // Memory modes, bank counts, configuration and access states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      fast_mode_one = 2'h0,
      fast_mode_four = 2'h1,
      slow_mode_one = 2'h2,
      slow_mode_two = 2'h3
   } dbat_mode_type;

   typedef enum logic [1:0] {
      banks_one = 2'h0,
      banks_two = 2'h1,
      banks_four = 2'h2,
      banks_rsvd = 2'h3
   } dbat_banks_type;

   typedef struct packed {
      logic parity_fitted;
      dbat_mode_type mode;
      dbat_banks_type banks;
      logic size_1m;
   } dbat_cfg_type;

   typedef enum logic [1:0] {
      st_idle = 2'h0,
      st_row = 2'h1,
      st_col = 2'h2,
      st_done = 2'h3
   } dbat_state_type;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic byte_lo;
      logic byte_hi;
      logic [23:1] cpu_word_addr;
   } dbat_mem_req_type;

   typedef struct packed {
      logic [3:0] row_strobe_n;
      logic [3:0] col_strobe_lo_n;
      logic [3:0] col_strobe_hi_n;
      logic write_en_n;
      logic [9:0] mux_addr;
   } dbat_dram_type;

endpackage

/* File: common/dbat_regs.svh */
// Register offsets, field positions, reset values and sequencing counts
// of the DRAM bank address translator.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data.
//
// Functional notes
// - One, two or four 16-bit banks
// - Each bank has low and high byte halves
// - Each byte half may carry a parity bit
// - 256K or 1M DRAM selected by configuration
// - Translation follows software-programmed size and banks
// - Local access drives strobes, write enable, address
// - Separate row, low, high strobes per bank
// - One shared write enable and address bus
// - Ten multiplexed outputs from CPU word address
// - Mapping depends on density, banks and mode
// - Row outputs 0..5 carry A13..A18 always
// - Fast 256K one bank row/column map
// - Fast 1M top output: A11/A21 row, A10 column
// - Two fast and two slow memory modes
// - Fast modes page-interleave, slow modes with two or four banks word-interleave
`ifndef DBAT_REGS_SVH
`define DBAT_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DBAT_CFG_OFS 8'h00
`define DBAT_STAT_OFS 8'h04
`define DBAT_COUNT_OFS 8'h08

// ---------------------------------------------------------------
// Configuration fields and reset value
// ---------------------------------------------------------------
`define DBAT_CFG_SIZE_BIT 0
`define DBAT_CFG_BANKS_LSB 1
`define DBAT_CFG_MODE_LSB 3
`define DBAT_CFG_PARITY_BIT 5
`define DBAT_CFG_RST 6'h00

// ---------------------------------------------------------------
// Access sequence: cycles from the taking edge to the done pulse
// ---------------------------------------------------------------
`define DBAT_DONE_LATENCY 3

`endif

/* File: src/dbat_top.sv */
// DRAM bank address translator: Wishbone configuration slave and
// a per-access row/column strobe sequencer for up to four banks.
// Assumes the request is synchronous to clock and held until done.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dbat_regs.svh"

module dbat_top
   import dbat_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire dbat_mem_req_type mem_req,
   output logic mem_done,
   output dbat_dram_type dram,
   output logic parity_en
);

   typedef struct packed {
      dbat_state_type st;
      dbat_cfg_type cfg;
      logic [23:1] addr;
      logic wr;
      logic lo;
      logic hi;
      logic [1:0] bank;
      logic [9:0] col;
      logic [15:0] count;
      dbat_dram_type dram;
      logic done;
      logic ack;
      logic [31:0] rdat;
   } dbat_top_state_type;

   dbat_top_state_type q;
   dbat_top_state_type d;
   logic [9:0] x_row;
   logic [9:0] x_col;
   logic [1:0] x_bank;
   logic wb_req;

   // ---------------------------------------------------------------
   // Address translation
   // ---------------------------------------------------------------
   dbat_xlate u_xlate (
      .cfg(q.cfg),
      .addr(mem_req.cpu_word_addr),
      .row(x_row),
      .col(x_col),
      .bank(x_bank)
   );

   assign wb_req = wb_cyc_i & wb_stb_i & ~q.ack;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = wb_req;
      d.done = 1'b0;
      // Register bus
      if (wb_req) begin
         d.rdat = 32'h0000_0000;
         case (wb_adr_i)
            `DBAT_CFG_OFS: begin
               d.rdat[5:0] = q.cfg;
               if (wb_we_i && wb_sel_i[0]) begin
                  d.cfg = dbat_cfg_type'(wb_dat_i[5:0]);
               end
            end
            `DBAT_STAT_OFS: begin
               d.rdat[1:0] = q.st;
               d.rdat[3:2] = q.bank;
               d.rdat[13:4] = q.col;
            end
            `DBAT_COUNT_OFS: begin
               d.rdat[15:0] = q.count;
            end
            default: begin
               d.rdat = 32'h0000_0000;
            end
         endcase
      end
      // Access sequencer
      case (q.st)
         st_idle: begin
            if (mem_req.valid) begin
               d.st = st_row;
               d.addr = mem_req.cpu_word_addr;
               d.wr = mem_req.write;
               d.lo = mem_req.byte_lo;
               d.hi = mem_req.byte_hi;
               d.bank = x_bank;
               d.col = x_col;
               d.dram.mux_addr = x_row;
               d.dram.row_strobe_n = ~(4'h1 << x_bank);
            end
         end
         st_row: begin
            d.st = st_col;
            d.dram.mux_addr = q.col;
            d.dram.write_en_n = ~q.wr;
            d.dram.col_strobe_lo_n = ~({3'h0, q.lo} << q.bank);
            d.dram.col_strobe_hi_n = ~({3'h0, q.hi} << q.bank);
         end
         st_col: begin
            d.st = st_done;
            d.done = 1'b1;
            d.count = q.count + 16'h0001;
            d.dram.row_strobe_n = 4'hf;
            d.dram.col_strobe_lo_n = 4'hf;
            d.dram.col_strobe_hi_n = 4'hf;
            d.dram.write_en_n = 1'b1;
         end
         default: begin
            d.st = st_idle;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.st <= st_idle;
         q.cfg <= dbat_cfg_type'(`DBAT_CFG_RST);
         q.dram.row_strobe_n <= 4'hf;
         q.dram.col_strobe_lo_n <= 4'hf;
         q.dram.col_strobe_hi_n <= 4'hf;
         q.dram.write_en_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign mem_done = q.done;
   assign dram = q.dram;
   assign parity_en = q.cfg.parity_fitted;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ---------------------------------------------------------------
   // Configuration decode for the checks
   // ---------------------------------------------------------------
   logic prop_slow;
   logic prop_multi;
   logic prop_four;
   logic prop_big;

   assign prop_slow = q.cfg.mode[1];
   assign prop_multi = (q.cfg.banks != banks_one);
   assign prop_four = q.cfg.banks[1];
   assign prop_big = q.cfg.size_1m;

   a_wb_ack_one: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle pulse");
   a_cfg_takes_write: assert property (
      wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `DBAT_CFG_OFS
      |=> q.cfg == $past(wb_dat_i[5:0]))
      else $error("configuration write not stored");
   a_done_latency: assert property (
      q.st == st_idle && mem_req.valid |-> ##3 mem_done)
      else $error("access done not three cycles after take");
   a_row_low_bits: assert property (
      q.st == st_row |-> dram.mux_addr[5:0] == q.addr[18:13])
      else $error("row outputs zero to five not A13 to A18");
   a_one_bank_row: assert property ($onehot0(~dram.row_strobe_n))
      else $error("more than one bank row strobe active");
   a_cas_bytes: assert property (
      q.st == st_col |-> dram.col_strobe_lo_n[q.bank] == !q.lo
                      && dram.col_strobe_hi_n[q.bank] == !q.hi
                      && !dram.row_strobe_n[q.bank])
      else $error("column strobes do not follow byte halves");
   a_we_shared: assert property (!dram.write_en_n |-> q.st == st_col && q.wr)
      else $error("write enable outside a write column phase");
   a_fast_small_map: assert property (
      q.st == st_col && !q.cfg.mode[1] && !q.cfg.size_1m && q.cfg.banks == banks_one
      |-> dram.mux_addr[8:0] == q.addr[9:1] && $past(dram.mux_addr[8:6]) ==
          {q.addr[10], q.addr[11], q.addr[12]})
      else $error("fast 256K single bank map wrong");
   a_big_top_bit: assert property (
      q.st == st_col && !q.cfg.mode[1] && q.cfg.size_1m
      |-> dram.mux_addr[9] == q.addr[10] && $past(dram.mux_addr[9]) ==
          ((q.cfg.banks == banks_one) ? q.addr[11] : q.addr[21]))
      else $error("1M top address bit wrong");
   a_slow_word_bank: assert property (
      q.st == st_row && q.cfg.mode[1] && q.cfg.banks == banks_two
      |-> q.bank == {1'b0, q.addr[1]})
      else $error("slow two bank selection not by word");

   // ---------------------------------------------------------------
   // Row phase
   // ---------------------------------------------------------------
   a_row_top_bit: assert property (
      q.st == st_row
      |-> dram.mux_addr[9] == (prop_big && (prop_multi ? q.addr[21] : q.addr[11])))
      else $error("row phase top address bit wrong");
   a_row_bit_eight: assert property (
      q.st == st_row
      |-> dram.mux_addr[8] == ((prop_big || prop_multi) ? q.addr[19] : q.addr[10]))
      else $error("row phase address bit eight wrong");
   a_row_bit_seven: assert property (
      q.st == st_row
      |-> dram.mux_addr[7] == ((prop_big || prop_four) ? q.addr[20] : q.addr[11]))
      else $error("row phase address bit seven wrong");
   a_row_bit_six: assert property (
      q.st == st_row
      |-> dram.mux_addr[6] ==
          ((prop_slow && prop_four && prop_big) ? q.addr[22] : q.addr[12]))
      else $error("row phase address bit six wrong");

   // ---------------------------------------------------------------
   // Column phase
   // ---------------------------------------------------------------
   a_col_page_map: assert property (
      q.st == st_col && (!prop_slow || !prop_multi)
      |-> dram.mux_addr == {prop_big & q.addr[10], q.addr[9:1]})
      else $error("page interleaved column address wrong");
   a_col_word_map: assert property (
      q.st == st_col && prop_slow && prop_multi
      |-> dram.mux_addr[8:2] == q.addr[9:3]
          && dram.mux_addr[1] == (prop_four ? q.addr[11] : q.addr[2])
          && dram.mux_addr[0] == q.addr[10]
          && dram.mux_addr[9] == (prop_big && (prop_four ? q.addr[12] : q.addr[11])))
      else $error("word interleaved column address wrong");

   // ---------------------------------------------------------------
   // Bank select
   // ---------------------------------------------------------------
   a_page_bank: assert property (
      q.st == st_row && (!prop_slow || !prop_multi)
      |-> q.bank[0] == (prop_multi && (prop_big ? q.addr[11] : q.addr[10]))
          && q.bank[1] == (prop_four && (prop_big ? q.addr[22] : q.addr[11])))
      else $error("page interleaved bank select wrong");
   a_slow_four_bank: assert property (
      q.st == st_row && prop_slow && prop_four
      |-> q.bank == q.addr[2:1])
      else $error("slow four bank selection not by word");
   a_row_strobe_bank: assert property (
      q.st == st_row |-> !dram.row_strobe_n[q.bank] && $onehot(~dram.row_strobe_n))
      else $error("row strobe not on the selected bank");

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   a_idle_quiet: assert property (
      q.st == st_idle
      |-> &{dram.row_strobe_n, dram.col_strobe_lo_n, dram.col_strobe_hi_n, dram.write_en_n})
      else $error("strobe active while no access runs");
   a_cas_after_ras: assert property (
      q.st == st_row |-> &dram.col_strobe_lo_n && &dram.col_strobe_hi_n)
      else $error("column strobe active in the row phase");
   a_row_after_take: assert property (
      q.st == st_idle && mem_req.valid
      |=> q.st == st_row && q.addr == $past(mem_req.cpu_word_addr))
      else $error("access not taken with its address");
   a_row_held: assert property (
      q.st == st_col |-> $stable(dram.row_strobe_n) && $stable(q.addr))
      else $error("row strobe moved during the column phase");
   a_we_follows: assert property (
      q.st == st_col |-> dram.write_en_n == !q.wr)
      else $error("write enable does not follow direction");
   a_done_pulse: assert property (
      mem_done |=> !mem_done)
      else $error("access done longer than one cycle");
   a_count_step: assert property (
      mem_done |-> q.count == $past(q.count) + 16'h0001)
      else $error("access count not advanced once per access");
   a_cfg_ignored: assert property (
      wb_req && wb_we_i && !wb_sel_i[0] |=> $stable(q.cfg))
      else $error("configuration changed without its byte lane");

   c_write_access: cover property (q.st == st_col && q.wr);
   c_read_access: cover property (q.st == st_col && !q.wr);
   c_slow_four: cover property (q.st == st_row && q.cfg.mode[1] && q.cfg.banks == banks_four);
   c_cfg_write: cover property (wb_req && wb_we_i && wb_adr_i == `DBAT_CFG_OFS);
   c_word_small: cover property (q.st == st_col && prop_slow && prop_multi && !prop_big);

endmodule

`default_nettype wire

/* File: src/dbat_xlate.sv */
// Combinational CPU word address to row, column and bank translation.
// Assumes a stable configuration while an access is being taken.
`timescale 1ns/1ps
`default_nettype none

module dbat_xlate
   import dbat_pkg::*;
(
   input wire dbat_cfg_type cfg,
   input wire logic [23:1] addr,
   output logic [9:0] row,
   output logic [9:0] col,
   output logic [1:0] bank
);

   logic slow;
   logic multi;
   logic four;

   always_comb begin
      slow = cfg.mode[1];
      multi = (cfg.banks != banks_one);
      four = cfg.banks[1];
      row = 10'h000;
      col = 10'h000;
      bank = 2'h0;
      row[5:0] = addr[18:13];
      row[6] = addr[12];
      row[7] = addr[11];
      row[8] = addr[10];
      col[8:0] = addr[9:1];
      if (!slow || !multi) begin
         // Banks interleaved by page
         if (cfg.size_1m) begin
            row[9] = multi ? addr[21] : addr[11];
            row[8] = addr[19];
            row[7] = addr[20];
            col[9] = addr[10];
            if (multi) begin
               bank = {four & addr[22], addr[11]};
            end
         end else if (multi) begin
            row[8] = addr[19];
            if (four) begin
               row[7] = addr[20];
               bank = {addr[11], addr[10]};
            end else begin
               bank = {1'b0, addr[10]};
            end
         end
      end else begin
         // Banks interleaved by word: low address bits pick the bank
         row[8] = addr[19];
         if (cfg.size_1m) begin
            row[9] = addr[21];
            row[7] = addr[20];
            col[9] = four ? addr[12] : addr[11];
            if (four) begin
               row[6] = addr[22];
            end
         end else if (four) begin
            row[7] = addr[20];
         end
         col[0] = addr[10];
         if (four) begin
            col[8:2] = addr[9:3];
            col[1] = addr[11];
            bank = addr[2:1];
         end else begin
            col[8:1] = addr[9:2];
            bank = {1'b0, addr[1]};
         end
      end
   end

endmodule

`default_nettype wire

/* File: verif/dbat_dram_model.sv */
// Stand-in for the DRAM banks: records what the last access strobed.
// Assumes active-low strobes sampled on the controller clock.
`timescale 1ns/1ps
`default_nettype none

module dbat_dram_model
   import dbat_pkg::*;
(
   input wire logic clock,
   input wire dbat_dram_type dram,
   output logic [3:0] row_mask,
   output logic [3:0] lo_mask,
   output logic [3:0] hi_mask,
   output logic [9:0] row,
   output logic [9:0] col,
   output logic wr
);
   logic ras_idle_q;
   logic cas_idle_q;

   // ---------------------------------------------------------------
   // Latch row on the first row strobe, column on the first column strobe
   // ---------------------------------------------------------------
   // One density for all banks: the array has no per-bank size
   always @(posedge clock) begin
      ras_idle_q <= &dram.row_strobe_n;
      cas_idle_q <= &{dram.col_strobe_lo_n, dram.col_strobe_hi_n};
      if (ras_idle_q && !(&dram.row_strobe_n)) begin
         row_mask <= ~dram.row_strobe_n;
         row <= dram.mux_addr;
      end
      if (cas_idle_q && !(&{dram.col_strobe_lo_n, dram.col_strobe_hi_n})) begin
         lo_mask <= ~dram.col_strobe_lo_n;
         hi_mask <= ~dram.col_strobe_hi_n;
         col <= dram.mux_addr;
         wr <= ~dram.write_en_n;
      end
   end
endmodule

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the DRAM bank address translator.
// Assumes the design, package and DRAM model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb
   import dbat_pkg::*;
;
   logic clock = 1'b0;
   logic arst_n, cyc, stb, we, ack, done, par;
   logic [7:0] adr;
   logic [3:0] sel, row_mask, lo_mask, hi_mask;
   logic [31:0] dat, wb_dat, rdat;
   logic [9:0] row, col;
   logic wr;
   dbat_mem_req_type req;
   dbat_dram_type dram;
   int err_count, n_tests, cycles;
   logic [5:0] cfgs [10] = '{6'h00, 6'h0a, 6'h04, 6'h11, 6'h0b, 6'h05,
                             6'h1a, 6'h1c, 6'h1d, 6'h1b};
   logic [23:1] addrs [2] = '{23'h6c3a55, 23'h13c5aa};
   logic [1:0] bp [3] = '{2'h2, 2'h1, 2'h3};

   always #2.5 clock = ~clock;

   dbat_top dbat_top_i (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat),
      .wb_ack_o(ack), .mem_req(req), .mem_done(done), .dram(dram), .parity_en(par));

   dbat_dram_model dbat_dram_model_i (.clock(clock), .dram(dram), .row_mask(row_mask),
      .lo_mask(lo_mask), .hi_mask(hi_mask), .row(row), .col(col), .wr(wr));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do @(posedge clock); while (ack !== 1'b1);
      rdat = wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask

   // Expected {bank, row, column} for a configuration and word address
   function automatic logic [21:0] xl(input dbat_cfg_type c, input logic [23:1] a);
      logic [9:0] r;
      logic [9:0] k;
      logic [1:0] b;
      logic big;
      logic four;
      r = {1'b0, a[10], a[11], a[12], a[18:13]};
      k = {1'b0, a[9:1]};
      b = 2'h0;
      big = (c.banks != banks_one);
      four = (c.banks == banks_four);
      if (big || c.size_1m) r[8] = a[19];
      if (c.banks == banks_four || c.size_1m) r[7] = a[20];
      if (c.size_1m) begin
         r[9] = big ? a[21] : a[11];
         k[9] = a[10];
      end
      if (big && c.mode[1]) begin
         b = four ? a[2:1] : {1'b0, a[1]};
         k[9] = c.size_1m && (four ? a[12] : a[11]);
         k[1] = four ? a[11] : a[2];
         k[0] = a[10];
         if (four && c.size_1m) r[6] = a[22];
      end else if (big) begin
         b = c.size_1m ? {c.banks == banks_four && a[22], a[11]}
                       : {c.banks == banks_four && a[11], a[10]};
      end
      return {b, r, k};
   endfunction

   task automatic acc(input logic [23:1] a, input logic w, input logic [1:0] by,
                      input logic [5:0] cf);
      logic [21:0] e;
      int n;
      e = xl(cf, a);
      n = 0;
      req <= {1'b1, w, by, a};
      @(posedge clock);
      req.valid <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (done !== 1'b1 && n < 20);
      chk(n, 3);
      chk({dram.row_strobe_n, dram.col_strobe_lo_n, dram.col_strobe_hi_n}, 12'hfff);
      chk(row_mask, 4'h1 << e[21:20]);
      chk(lo_mask, by[1] ? 4'h1 << e[21:20] : 4'h0);
      chk(hi_mask, by[0] ? 4'h1 << e[21:20] : 4'h0);
      chk(row, e[19:10]);
      chk(col, e[9:0]);
      chk(wr, w);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk(dram, {13'h1fff, 10'h0});
      chk(par, 1'b0);
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(rdat, 32'h0);
   endtask

   task automatic t_regs;
      wb(1'b1, 8'h00, 32'h3f, 4'he);
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(rdat, 32'h0);
      wb(1'b1, 8'h00, 32'h20, 4'h1);
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(rdat, 32'h20);
      chk(par, 1'b1);
      wb(1'b0, 8'h10, 32'h0, 4'hf);
      chk(rdat, 32'h0);
   endtask

   // Every density, bank count and mode, two addresses each
   task automatic t_map;
      logic [21:0] e;
      int k;
      k = 0;
      for (int i = 0; i < 10; i++) begin
         wb(1'b1, 8'h00, {26'h0, cfgs[i]}, 4'h1);
         for (int j = 0; j < 2; j++) begin
            acc(addrs[j], k[0], bp[k % 3], cfgs[i]);
            k++;
         end
      end
      e = xl(cfgs[9], addrs[1]);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk(rdat[13:0], {e[9:0], e[21:20], 2'h0});
      wb(1'b0, 8'h08, 32'h0, 4'hf);
      chk(rdat[15:0], 16'h0014);
   endtask

   // Reset in mid-run clears configuration and access count
   task automatic t_rerun;
      wb(1'b1, 8'h00, 32'h20, 4'h1);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk(par, 1'b0);
      wb(1'b0, 8'h08, 32'h0, 4'hf);
      chk(rdat, 32'h0);
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk(rdat, 32'h0);
      acc(addrs[0], 1'b1, 2'h3, 6'h00);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
      req = '0;
      err_count = 0;
      n_tests = 0;
      cycles = 0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_reset;
      t_regs;
      t_map;
      t_rerun;
      complete_run;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         complete_run;
      end
   end
endmodule

`default_nettype wire
